// File: rtl/sbcwd_core.sv
// Serial link, mode control, window watchdog, interrupt and switch gating
//
// Contract
// - A change on either level input wakes the device from Sleep or Stop.
// - In Normal mode the status word reports both level inputs.
// - Switches a and b drive only when their control bit and PWM gate are high.
// - Switch c follows its control bit only; PWM gate has no effect; the code also turns it off on thermal shutdown and in Sleep and Stop.
// - Current-sense amplifier enabled in Normal mode only.
// - Config pin open gives 150 ms period; tied to ground disables watchdog.
// - Resistor period in ms is 0.991 times kilohms plus 0.648.
// - Serial output changes on the falling serial clock edge.
// - Serial input sampled on the rising serial clock edge.
// - Serial output not driven while chip select is high.
// - Transfer framed by chip select low; activity ignored while it is high.
// - Interrupt pulses low on overtemp, switch shutdown, overvoltage or undervoltage; the code raises no fault interrupt in Sleep or Stop.
// - After an interrupt the next read has bit 7 set and source bits.
// - Wake from Stop by level input or LIN drives interrupt low.
// - Receive output low while LIN is dominant, high while recessive.
// - LIN driven dominant while transmit input is low, else recessive; the code holds it recessive in Sleep and Stop whatever the transmit input.
// - Clear in closed window or missing clear asserts reset and resets device.
// - First clear during Normal Request is accepted any time.
// - Sleep switches supply output off; Stop uses only standby regulator.
// - Reset output asserted by supply low detection and by watchdog failure.
// - Each transfer is one byte, most significant bit first.
// - Status snapshot latched at chip select fall and shifted out.
`timescale 1ns/10ps
`include "sbcwd_params.svh"
module sbcwd_core #(
   parameter int CYC_PER_US = `SBCWD_CLK_MHZ,
   parameter int NREQ_CYC   = `SBCWD_NREQ_MS * `SBCWD_US_PER_MS * `SBCWD_CLK_MHZ,
   parameter int DEF_CYC    = `SBCWD_DEF_PERIOD_MS * `SBCWD_US_PER_MS * `SBCWD_CLK_MHZ
) (
   // System clock and reset
   input  wire logic                  CLOCK,
   input  wire logic                  RST_N,
   // Serial link from the host
   input  wire logic                  SCLK,
   input  wire logic                  CS_N,
   input  wire logic                  MOSI,
   output logic                       MISO_O,
   output logic                       MISO_OE,
   // Level inputs and PWM gate
   input  wire logic                  LEVEL_INPUT_A,
   input  wire logic                  LEVEL_INPUT_B,
   input  wire logic                  PWM_GATE_IN,
   // Fault monitors and supply low detection
   input  wire sbcwd_pkg::sbcwd_fault_t FAULTS,
   input  wire logic                  VDD_LOW,
   // Watchdog period configuration strap
   input  wire logic                  WD_CFG_OPEN,
   input  wire logic                  WD_CFG_GROUNDED,
   input  wire logic [9:0]            WD_CFG_KOHM,
   // LIN transceiver digital side
   input  wire logic                  LIN_BUS_IN,
   input  wire logic                  LIN_TX_IN,
   output logic                       LIN_DRIVE_DOM,
   output logic                       LIN_RX_OUT,
   // Switch, amplifier and supply controls
   output logic                       HIGH_SIDE_SWITCH_A_EN,
   output logic                       HIGH_SIDE_SWITCH_B_EN,
   output logic                       HIGH_SIDE_SWITCH_C_EN,
   output logic                       AMP_EN,
   output logic                       VDD_MAIN_EN,
   output logic                       VDD_STBY_EN,
   // Host notification
   output logic                       INT_N,
   output logic                       RST_OUT_N
);
   localparam logic [31:0] SLOPE     = 32'(`SBCWD_SLOPE_US_PER_KOHM);
   localparam logic [31:0] OFFSET    = 32'(`SBCWD_OFFSET_US);
   localparam logic [4:0]  INT_PULSE = 5'(`SBCWD_INT_PULSE_CYC);
   localparam logic [5:0]  RST_PULSE = 6'(`SBCWD_RST_PULSE_CYC);

   // Link domain: receive side
   logic [2:0]            rx_cnt_r;
   logic [6:0]            rx_sh_r;
   logic [7:0]            rx_byte_r;
   logic                  byte_tgl_r;
   // Link domain: transmit side
   logic [2:0]            tx_idx_r;
   logic [7:0]            snap_r;
   // System domain
   logic [`SBCWD_SYNC_W-1:0] sync1_r;
   logic [`SBCWD_SYNC_W-1:0] sync2_r;
   logic [`SBCWD_SYNC_W-1:0] prev_r;
   sbcwd_pkg::sbcwd_mode_t   mode_r;
   sbcwd_pkg::sbcwd_status_t status_r;
   sbcwd_pkg::sbcwd_fault_t  fault_s;
   sbcwd_pkg::sbcwd_fault_t  fault_rise;
   logic [2:0]            hs_ctrl_r;
   logic [7:0]            lp_last_r;
   logic                  lp_armed_r;
   logic [31:0]           wd_cnt_r;
   logic [31:0]           wd_per_r;
   logic [4:0]            int_cnt_r;
   logic [5:0]            rst_cnt_r;
   logic                  int_flag_r;
   logic [6:0]            src_r;
   logic                  rd_had_flag_r;
   logic                  lin_dom_r;
   logic                  lin_rx_r;
   logic                  cs_fall;
   logic                  cs_rise;
   logic                  byte_evt;
   logic                  lvl_chg;
   logic                  lin_wake;
   logic                  wake;
   logic                  active;
   logic                  is_lp;
   logic                  wd_clear;
   logic                  lp_enter;
   logic                  wd_en;
   logic                  wd_fail;
   logic                  fault_evt;
   logic                  stop_wake;
   logic                  int_set;
   logic [6:0]            src_set;
   logic                  pwm_s;
   logic [31:0]           half;

   // Receive shift register; chip select high holds it cleared
   always_ff @(posedge SCLK or posedge CS_N) begin
      if (CS_N) begin
         rx_cnt_r <= 3'h0;
         rx_sh_r  <= 7'h00;
      end else begin
         rx_cnt_r <= rx_cnt_r + 3'h1;
         rx_sh_r  <= {rx_sh_r[5:0], MOSI};
      end
   end

   // Byte hand-off: data stays put for a full byte time, so a toggle suffices
   always_ff @(posedge SCLK or negedge RST_N) begin
      if (!RST_N) begin
         rx_byte_r  <= 8'h00;
         byte_tgl_r <= 1'b0;
      end else if (!CS_N && rx_cnt_r == 3'h7) begin
         rx_byte_r  <= {rx_sh_r, MOSI};
         byte_tgl_r <= ~byte_tgl_r;
      end
   end

   // Status is a flop of the system domain and changes rarely; taken at select fall
   always_ff @(negedge CS_N or negedge RST_N) begin
      if (!RST_N) begin
         snap_r <= 8'h00;
      end else begin
         snap_r <= status_r;
      end
   end

   // Bit index advances on falling edges; assumes the clock idles low
   always_ff @(negedge SCLK or posedge CS_N) begin
      if (CS_N) begin
         tx_idx_r <= 3'h0;
      end else begin
         tx_idx_r <= tx_idx_r + 3'h1;
      end
   end

   assign MISO_O  = snap_r[~tx_idx_r];
   assign MISO_OE = !CS_N;

   // Two-flop synchronisers for pins, straps and the byte toggle
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         sync1_r <= `SBCWD_SYNC_RST;
         sync2_r <= `SBCWD_SYNC_RST;
         prev_r  <= `SBCWD_SYNC_RST;
      end else begin
         sync1_r <= {WD_CFG_KOHM, byte_tgl_r, WD_CFG_GROUNDED, WD_CFG_OPEN, LIN_TX_IN, LIN_BUS_IN,
                     VDD_LOW, FAULTS, PWM_GATE_IN, LEVEL_INPUT_B, LEVEL_INPUT_A, CS_N};
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   always_comb begin
      fault_s    = sbcwd_pkg::sbcwd_fault_t'(sync2_r[`SBCWD_SYNC_FLT_HI:`SBCWD_SYNC_FLT_LO]);
      fault_rise = fault_s & ~sbcwd_pkg::sbcwd_fault_t'(prev_r[`SBCWD_SYNC_FLT_HI:`SBCWD_SYNC_FLT_LO]);
   end

   assign pwm_s    = sync2_r[`SBCWD_SYNC_PWM];
   assign cs_fall  = !sync2_r[`SBCWD_SYNC_CS] && prev_r[`SBCWD_SYNC_CS];
   assign cs_rise  = sync2_r[`SBCWD_SYNC_CS] && !prev_r[`SBCWD_SYNC_CS];
   assign byte_evt = sync2_r[`SBCWD_SYNC_TGL] ^ prev_r[`SBCWD_SYNC_TGL];
   assign lvl_chg  = (sync2_r[`SBCWD_SYNC_LVL_A] ^ prev_r[`SBCWD_SYNC_LVL_A]) ||
                     (sync2_r[`SBCWD_SYNC_LVL_B] ^ prev_r[`SBCWD_SYNC_LVL_B]);
   assign lin_wake = !sync2_r[`SBCWD_SYNC_LIN_BUS] && prev_r[`SBCWD_SYNC_LIN_BUS];
   assign active   = (mode_r == sbcwd_pkg::SBCWD_NREQ) || (mode_r == sbcwd_pkg::SBCWD_NORMAL);
   assign wake     = !active && (lvl_chg || lin_wake);
   assign stop_wake = (mode_r == sbcwd_pkg::SBCWD_STOP) && wake;

   // Command decode
   assign is_lp    = rx_byte_r[7:6] == `SBCWD_CMD_LP_TOP && rx_byte_r[4:1] == `SBCWD_CMD_LP_MID;
   assign wd_clear = byte_evt && !is_lp && active;
   assign lp_enter = byte_evt && is_lp && lp_armed_r && rx_byte_r == lp_last_r &&
                     mode_r == sbcwd_pkg::SBCWD_NORMAL;

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         lp_armed_r <= 1'b0;
         lp_last_r  <= 8'h00;
      end else if (byte_evt) begin
         lp_armed_r <= is_lp;
         lp_last_r  <= rx_byte_r;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         hs_ctrl_r <= 3'h0;
      end else if (wd_fail || !active) begin
         hs_ctrl_r <= 3'h0;
      end else if (wd_clear) begin
         hs_ctrl_r <= rx_byte_r[4:2];
      end
   end

   // Watchdog period from the strap; no 10-bit kilohm value can wrap it at 50 MHz
   assign wd_en = !sync2_r[`SBCWD_SYNC_CFG_GND];
   assign half  = wd_per_r >> 1;

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         wd_per_r <= 32'(DEF_CYC);
      end else if (sync2_r[`SBCWD_SYNC_CFG_OPEN]) begin
         wd_per_r <= 32'(DEF_CYC);
      end else begin
         wd_per_r <= (32'(sync2_r[`SBCWD_SYNC_KOHM_HI:`SBCWD_SYNC_KOHM_LO]) * SLOPE + OFFSET)
                     * 32'(CYC_PER_US);
      end
   end

   always_comb begin
      wd_fail = 1'b0;
      if (wd_en) begin
         unique case (mode_r)
            sbcwd_pkg::SBCWD_NREQ:
               wd_fail = !wd_clear && wd_cnt_r >= 32'(NREQ_CYC) - 32'h1;
            sbcwd_pkg::SBCWD_NORMAL:
               wd_fail = wd_clear ? (wd_cnt_r < half) : (wd_cnt_r >= wd_per_r - 32'h1);
            sbcwd_pkg::SBCWD_SLEEP,
            sbcwd_pkg::SBCWD_STOP:
               wd_fail = 1'b0;
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         wd_cnt_r <= 32'h0;
      end else if (!wd_en || !active || wd_clear || wd_fail) begin
         wd_cnt_r <= 32'h0;
      end else begin
         wd_cnt_r <= wd_cnt_r + 32'h1;
      end
   end

   // Mode control; a watchdog failure restarts from Normal Request
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         mode_r <= sbcwd_pkg::SBCWD_NREQ;
      end else if (wd_fail) begin
         mode_r <= sbcwd_pkg::SBCWD_NREQ;
      end else begin
         unique case (mode_r)
            sbcwd_pkg::SBCWD_NREQ:
               if (wd_clear) begin
                  mode_r <= sbcwd_pkg::SBCWD_NORMAL;
               end
            sbcwd_pkg::SBCWD_NORMAL:
               if (lp_enter) begin
                  mode_r <= rx_byte_r[0] ? sbcwd_pkg::SBCWD_STOP : sbcwd_pkg::SBCWD_SLEEP;
               end
            sbcwd_pkg::SBCWD_SLEEP,
            sbcwd_pkg::SBCWD_STOP:
               if (wake) begin
                  mode_r <= sbcwd_pkg::SBCWD_NREQ;
               end
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rst_cnt_r <= 6'h00;
      end else if (wd_fail) begin
         rst_cnt_r <= RST_PULSE;
      end else if (rst_cnt_r != 6'h00) begin
         rst_cnt_r <= rst_cnt_r - 6'h01;
      end
   end

   assign RST_OUT_N = !(sync2_r[`SBCWD_SYNC_VDD_LOW] || rst_cnt_r != 6'h00);

   // Interrupt sources; monitors are off outside the active modes
   assign fault_evt = active && (|fault_rise);
   assign int_set   = fault_evt || stop_wake;
   // Status order is overvoltage, undervoltage, overtemp, switch shutdown from bit 5 down
   assign src_set   = {stop_wake && lin_wake,
                       active ? {fault_rise.supply_overvoltage, fault_rise.supply_undervoltage,
                                 fault_rise.regulator_overtemp_warning, fault_rise.hs_thermal_shutdown} : 4'h0,
                       stop_wake && lvl_chg && (sync2_r[`SBCWD_SYNC_LVL_B] ^ prev_r[`SBCWD_SYNC_LVL_B]),
                       stop_wake && lvl_chg && (sync2_r[`SBCWD_SYNC_LVL_A] ^ prev_r[`SBCWD_SYNC_LVL_A])};

   // Flag clears only after a read that carried it; a new event in that cycle wins
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         int_flag_r    <= 1'b0;
         src_r         <= 7'h00;
         rd_had_flag_r <= 1'b0;
      end else begin
         if (cs_fall) begin
            rd_had_flag_r <= int_flag_r;
         end
         if (cs_rise && rd_had_flag_r) begin
            int_flag_r <= int_set;
            src_r      <= src_set;
         end else begin
            int_flag_r <= int_flag_r || int_set;
            src_r      <= src_r | src_set;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         int_cnt_r <= 5'h00;
      end else if (int_set) begin
         int_cnt_r <= INT_PULSE;
      end else if (int_cnt_r != 5'h00) begin
         int_cnt_r <= int_cnt_r - 5'h01;
      end
   end

   assign INT_N = int_cnt_r == 5'h00;

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         status_r <= '0;
      end else if (int_flag_r) begin
         status_r <= {1'b1, src_r};
      end else begin
         status_r <= {1'b0, 1'b0, fault_s.supply_overvoltage, fault_s.supply_undervoltage,
                      fault_s.regulator_overtemp_warning, fault_s.hs_thermal_shutdown,
                      (mode_r == sbcwd_pkg::SBCWD_NORMAL) && sync2_r[`SBCWD_SYNC_LVL_B],
                      (mode_r == sbcwd_pkg::SBCWD_NORMAL) && sync2_r[`SBCWD_SYNC_LVL_A]};
      end
   end

   // LIN path; bus held recessive outside the active modes
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         lin_dom_r <= 1'b0;
         lin_rx_r  <= 1'b1;
      end else begin
         lin_dom_r <= active && !sync2_r[`SBCWD_SYNC_LIN_TX];
         lin_rx_r  <= sync2_r[`SBCWD_SYNC_LIN_BUS];
      end
   end

   // Gated by mode so the bus is released in the very cycle a low-power mode starts
   assign LIN_DRIVE_DOM = lin_dom_r && active;
   assign LIN_RX_OUT    = lin_rx_r;

   // Thermal shutdown turns all switches off
   assign HIGH_SIDE_SWITCH_A_EN = active && !fault_s.hs_thermal_shutdown && hs_ctrl_r[0] && pwm_s;
   assign HIGH_SIDE_SWITCH_B_EN = active && !fault_s.hs_thermal_shutdown && hs_ctrl_r[1] && pwm_s;
   assign HIGH_SIDE_SWITCH_C_EN = active && !fault_s.hs_thermal_shutdown && hs_ctrl_r[2];
   assign AMP_EN      = mode_r == sbcwd_pkg::SBCWD_NORMAL;
   assign VDD_MAIN_EN = active;
   assign VDD_STBY_EN = mode_r == sbcwd_pkg::SBCWD_STOP;

   sequence s_early_clear;
      mode_r == sbcwd_pkg::SBCWD_NORMAL && wd_en && wd_clear && wd_cnt_r < half;
   endsequence
   sequence s_fault_evt;
      active && (|fault_rise);
   endsequence

   property p_hs_pwm;
      @(posedge CLOCK) disable iff (!RST_N) !pwm_s |-> !HIGH_SIDE_SWITCH_A_EN && !HIGH_SIDE_SWITCH_B_EN;
   endproperty
   a_hs_pwm: assert property (p_hs_pwm) else $error("switch on while PWM gate low");

   property p_hs_c_free;
      @(posedge CLOCK) disable iff (!RST_N)
         $changed(pwm_s) && $stable(hs_ctrl_r) && $stable(mode_r) && $stable(fault_s) |->
         $stable(HIGH_SIDE_SWITCH_C_EN);
   endproperty
   a_hs_c_free: assert property (p_hs_c_free) else $error("switch c moved with PWM gate");

   property p_amp_off;
      @(posedge CLOCK) disable iff (!RST_N) lp_enter |=> !AMP_EN && !VDD_MAIN_EN == 1'b1;
   endproperty
   a_amp_off: assert property (p_amp_off) else $error("amplifier on after low-power entry");

   property p_wd_off;
      @(posedge CLOCK) disable iff (!RST_N) !wd_en |-> !wd_fail ##1 rst_cnt_r == 6'h00 || $past(wd_fail);
   endproperty
   a_wd_off: assert property (p_wd_off) else $error("watchdog fired while disabled");

   property p_closed;
      @(posedge CLOCK) disable iff (!RST_N) s_early_clear |=> !RST_OUT_N [*4] ##1 mode_r == sbcwd_pkg::SBCWD_NREQ;
   endproperty
   a_closed: assert property (p_closed) else $error("closed-window clear did not reset");

   property p_nreq_clear;
      @(posedge CLOCK) disable iff (!RST_N)
         mode_r == sbcwd_pkg::SBCWD_NREQ && wd_clear |=> mode_r == sbcwd_pkg::SBCWD_NORMAL && rst_cnt_r == 6'h00;
   endproperty
   a_nreq_clear: assert property (p_nreq_clear) else $error("first clear rejected");

   property p_fault_int;
      @(posedge CLOCK) disable iff (!RST_N) s_fault_evt |=> !INT_N [*8] ##1 int_flag_r;
   endproperty
   a_fault_int: assert property (p_fault_int) else $error("fault did not pulse interrupt");

   property p_stop_wake;
      @(posedge CLOCK) disable iff (!RST_N) stop_wake |=> !INT_N && mode_r == sbcwd_pkg::SBCWD_NREQ;
   endproperty
   a_stop_wake: assert property (p_stop_wake) else $error("stop wake not notified");

   property p_sleep_supply;
      @(posedge CLOCK) disable iff (!RST_N)
         mode_r == sbcwd_pkg::SBCWD_SLEEP |-> !VDD_MAIN_EN && !VDD_STBY_EN && !LIN_DRIVE_DOM;
   endproperty
   a_sleep_supply: assert property (p_sleep_supply) else $error("supply on in sleep");

   property p_miso_float;
      @(posedge CLOCK) disable iff (!RST_N) CS_N |-> !MISO_OE;
   endproperty
   a_miso_float: assert property (p_miso_float) else $error("serial output driven while deselected");

   property p_vdd_rst;
      @(posedge CLOCK) disable iff (!RST_N) $rose(sync2_r[`SBCWD_SYNC_VDD_LOW]) |-> !RST_OUT_N;
   endproperty
   a_vdd_rst: assert property (p_vdd_rst) else $error("supply low without reset");

   property p_lin_tx;
      @(posedge CLOCK) disable iff (!RST_N) active && !sync2_r[`SBCWD_SYNC_LIN_TX] |=> LIN_DRIVE_DOM;
   endproperty
   a_lin_tx: assert property (p_lin_tx) else $error("LIN not dominant with transmit low");
endmodule

// File: rtl/sbcwd_params.svh
// Constants for the system basis chip serial, watchdog and control core
`ifndef SBCWD_PARAMS_SVH
`define SBCWD_PARAMS_SVH
`define SBCWD_CLK_MHZ 50
`define SBCWD_US_PER_MS 1000
`define SBCWD_NREQ_MS 150
`define SBCWD_DEF_PERIOD_MS 150
`define SBCWD_SLOPE_US_PER_KOHM 991
`define SBCWD_OFFSET_US 648
`define SBCWD_INT_PULSE_CYC 16
`define SBCWD_RST_PULSE_CYC 32
`define SBCWD_CMD_LP_TOP 2'h3
`define SBCWD_CMD_LP_MID 4'h0
`define SBCWD_SYNC_W 24
`define SBCWD_SYNC_RST 24'h000601
`define SBCWD_SYNC_CS 0
`define SBCWD_SYNC_LVL_A 1
`define SBCWD_SYNC_LVL_B 2
`define SBCWD_SYNC_PWM 3
`define SBCWD_SYNC_FLT_LO 4
`define SBCWD_SYNC_FLT_HI 7
`define SBCWD_SYNC_VDD_LOW 8
`define SBCWD_SYNC_LIN_BUS 9
`define SBCWD_SYNC_LIN_TX 10
`define SBCWD_SYNC_CFG_OPEN 11
`define SBCWD_SYNC_CFG_GND 12
`define SBCWD_SYNC_TGL 13
`define SBCWD_SYNC_KOHM_LO 14
`define SBCWD_SYNC_KOHM_HI 23
`endif

// File: rtl/sbcwd_pkg.sv
// Types shared by the system basis chip control core
package sbcwd_pkg;
   typedef enum logic [1:0] {SBCWD_NREQ, SBCWD_NORMAL, SBCWD_SLEEP, SBCWD_STOP} sbcwd_mode_t;
   typedef struct packed {
      logic regulator_overtemp_warning;
      logic hs_thermal_shutdown;
      logic supply_overvoltage;
      logic supply_undervoltage;
   } sbcwd_fault_t;
   typedef struct packed {
      logic intsrc;
      logic lin_wakeup;
      logic supply_overvoltage;
      logic supply_undervoltage;
      logic regulator_overtemp_warning;
      logic hs_thermal_shutdown;
      logic level_input_b;
      logic level_input_a;
   } sbcwd_status_t;
endpackage

// File: test/sbcwd_host.sv
// Host model: serial master sending one byte per chip-select frame
`timescale 1ns/10ps
module sbcwd_host (
   // Serial link
   output logic      SCLK,
   output logic      CS_N,
   output logic      MOSI,
   input  wire logic MISO_O,
   input  wire logic MISO_OE
);
   initial begin
      SCLK = 1'b0;
      CS_N = 1'b1;
      MOSI = 1'b0;
   end
   // Clock stands low outside frames; data released to its inverse
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      CS_N = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         MOSI = tx[i];
         #7.5 SCLK = 1'b1;
         rx[i] = MISO_O;
         #7.5 SCLK = 1'b0;
      end
      #7.5 CS_N = 1'b1;
      MOSI = ~MOSI;
   endtask
endmodule

// File: test/tb.sv
// Self-checking bench for the control core
`timescale 1ns/10ps
module tb;
   logic CLOCK = 1'b0;
   logic RST_N = 1'b0;
   logic SCLK, CS_N, MOSI, MISO_O, MISO_OE, DOM, RX, SA, SB, SC, AMP, VM, VS, INT_N, RO_N;
   logic LA = 1'b0, LB = 1'b0, PWM = 1'b0, VLOW = 1'b0, TX = 1'b1, BUS = 1'b1, GND_CFG = 1'b0;
   sbcwd_pkg::sbcwd_fault_t FLT = 4'h0;
   logic [7:0] rx;
   int fails = 0, total_checks = 0, cyc = 0, n, w;
   sbcwd_host sbcwd_host_inst (.SCLK(SCLK), .CS_N(CS_N), .MOSI(MOSI), .MISO_O(MISO_O), .MISO_OE(MISO_OE));
   sbcwd_core #(.CYC_PER_US(1), .NREQ_CYC(2000), .DEF_CYC(2000)) sbcwd_core_inst (
      .CLOCK(CLOCK), .RST_N(RST_N), .SCLK(SCLK), .CS_N(CS_N), .MOSI(MOSI), .MISO_O(MISO_O),
      .MISO_OE(MISO_OE), .LEVEL_INPUT_A(LA), .LEVEL_INPUT_B(LB), .PWM_GATE_IN(PWM), .FAULTS(FLT),
      .VDD_LOW(VLOW), .WD_CFG_OPEN(1'b1), .WD_CFG_GROUNDED(GND_CFG), .WD_CFG_KOHM(10'h001),
      .LIN_BUS_IN(BUS), .LIN_TX_IN(TX), .LIN_DRIVE_DOM(DOM), .LIN_RX_OUT(RX),
      .HIGH_SIDE_SWITCH_A_EN(SA), .HIGH_SIDE_SWITCH_B_EN(SB), .HIGH_SIDE_SWITCH_C_EN(SC),
      .AMP_EN(AMP), .VDD_MAIN_EN(VM), .VDD_STBY_EN(VS), .INT_N(INT_N), .RST_OUT_N(RO_N));
   always #10 CLOCK = ~CLOCK;
   always @(posedge CLOCK) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         conclude();
      end
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask
   task automatic step(int k);
      repeat (k) @(posedge CLOCK);
      #1;
   endtask
   // Gap after each byte keeps the host inside the allowed spacing
   task automatic send(logic [7:0] b);
      sbcwd_host_inst.xfer(b, rx);
      step(12);
      chk("miso_oe", 8'h00, {7'h0, MISO_OE});
   endtask
   task automatic rst;
      {LA, LB, PWM, VLOW, TX, BUS, FLT} = 10'h030;
      RST_N = 1'b0;
      GND_CFG = 1'b0;
      step(5);
      RST_N = 1'b1;
      step(5);
   endtask
   task automatic wait_int;
      n = 0;
      while (INT_N !== 1'b0 && n < 20) begin
         step(1);
         n++;
      end
   endtask
   task automatic t_switch;
      rst();
      LA = 1'b1;
      send(8'h1C);
      PWM = 1'b1;
      step(4);
      chk("sw_pwm_hi", 8'h07, {5'h0, SA, SB, SC});
      PWM = 1'b0;
      step(4);
      chk("sw_pwm_lo", 8'h01, {5'h0, SA, SB, SC});
      chk("amp", 8'h01, {7'h0, AMP});
      send(8'h1C);
      chk("status", 8'h01, rx);
      $display("end switch");
   endtask
   task automatic t_lin;
      rst();
      TX = 1'b0;
      step(4);
      chk("lin_dom", 8'h01, {7'h0, DOM});
      {TX, BUS} = 2'b10;
      step(4);
      chk("lin_rx", 8'h00, {6'h0, DOM, RX});
      BUS = 1'b1;
      step(4);
      chk("lin_rec", 8'h01, {7'h0, RX});
      $display("end lin");
   endtask
   task automatic t_int;
      logic [7:0] ex [4] = '{8'h90, 8'hA0, 8'h84, 8'h88};
      for (int i = 0; i < 4; i++) begin
         rst();
         send(8'h00);
         FLT = 4'(1 << i);
         wait_int();
         w = 0;
         while (INT_N === 1'b0 && w < 40) begin
            step(1);
            w++;
         end
         chk("int_len", 8'd16, 8'(w));
         FLT = 4'h0;
         step(5);
         send(8'h00);
         chk("int_src", ex[i], rx);
      end
      $display("end int");
   endtask
   task automatic t_lowpwr;
      rst();
      send(8'h00);
      send(8'hC1);
      send(8'hC1);
      chk("stop", 8'h02, {5'h0, VM, VS, AMP});
      LB = 1'b1;
      wait_int();
      chk("wake_int", 8'h00, {7'h0, INT_N});
      step(3);
      chk("woken", 8'h04, {5'h0, VM, VS, AMP});
      send(8'h00);
      send(8'hC0);
      send(8'hC0);
      chk("sleep", 8'h00, {5'h0, VM, VS, AMP});
      LA = 1'b1;
      step(6);
      chk("sleep_wake", 8'h01, {7'h0, VM});
      $display("end lowpwr");
   endtask
   task automatic t_wdoff;
      rst();
      GND_CFG = 1'b1;
      step(3);
      send(8'h00);
      send(8'h00);
      chk("wdoff_early", 8'h01, {7'h0, RO_N});
      step(2100);
      chk("wdoff_long", 8'h03, {6'h0, RO_N, AMP});
      $display("end wdoff");
   endtask
   task automatic t_wdog;
      rst();
      send(8'h00);
      step(1500);
      send(8'h00);
      step(50);
      chk("open_clear", 8'h01, {7'h0, RO_N});
      send(8'h00);
      chk("closed_clear", 8'h00, {7'h0, RO_N});
      w = 0;
      while (RO_N === 1'b0 && w < 60) begin
         step(1);
         w++;
      end
      n = 0;
      while (RO_N === 1'b1 && n < 2100) begin
         step(1);
         n++;
      end
      chk("nreq_timeout", 8'h01, {7'h0, n > 1900 && RO_N === 1'b0});
      step(40);
      VLOW = 1'b1;
      step(4);
      chk("vdd_low", 8'h00, {7'h0, RO_N});
      $display("end wdog");
   endtask
   initial begin
      t_switch();
      t_lin();
      t_int();
      t_lowpwr();
      t_wdoff();
      t_wdog();
      conclude();
   end
endmodule
